// ==== common/pafm_pkg.sv ====
`default_nettype none
package pafm_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [3:0] ADR_PA_ADDR = 4'h0;
    localparam logic [3:0] ADR_PA_CTL  = 4'h1;
    localparam logic [3:0] ADR_PB_ADDR = 4'h2;
    localparam logic [3:0] ADR_PB_CTL  = 4'h3;
    localparam logic [3:0] ADR_PC_ADDR = 4'h4;
    localparam logic [3:0] ADR_PC_CTL  = 4'h5;
    localparam logic [3:0] ADR_LED_EN  = 4'h6;
    localparam logic [3:0] ADR_LED_HI  = 4'h7;
    localparam logic [3:0] ADR_LED_LO  = 4'h8;
    localparam logic [3:0] ADR_PA_IN   = 4'h9;
    localparam logic [3:0] ADR_PB_IN   = 4'hA;
    localparam logic [3:0] ADR_PC_IN   = 4'hB;
    localparam logic [3:0] ADR_PA_OUT  = 4'hC;
    localparam logic [3:0] ADR_PB_OUT  = 4'hD;
    localparam logic [3:0] ADR_PC_OUT  = 4'hE;

    // ------------------------------------------------------------
    // Subregister indices
    // ------------------------------------------------------------
    localparam logic [7:0] SUB_DIR  = 8'h01;
    localparam logic [7:0] SUB_AF   = 8'h02;
    localparam logic [7:0] SUB_FS1  = 8'h07;
    localparam logic [7:0] SUB_FS2  = 8'h08;

    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [7:0] RST_DIR  = 8'hFF;

    // ------------------------------------------------------------
    // Pin positions and LED levels
    // ------------------------------------------------------------
    localparam int PIN_CLK      = 3;
    localparam int PIN_VREF_B   = 5;
    localparam int PIN_VREF_C   = 2;
    localparam int PIN_RESET_A  = 2;
    localparam int PIN_COMPARATOR_RESULT_OUT     = 3;
    localparam logic [7:0] PB_ANALOG_MASK = 8'h1F;
    localparam logic [7:0] PC_LED_MASK    = 8'hFF;

    typedef enum logic [1:0] {
        LED_3MA,
        LED_7MA,
        LED_13MA,
        LED_20MA
    } pafm_led_e;

    typedef enum logic [1:0] {
        PKG_8PIN,
        PKG_20PIN,
        PKG_28PIN
    } pafm_pkg_e;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] sel;
        logic [7:0] dir;
        logic [7:0] af;
        logic [7:0] fs1;
        logic [7:0] fs2;
        logic [7:0] dout;
    } pafm_port_s;

    typedef struct packed {
        logic [7:0] oe;
        logic [7:0] o;
    } pafm_pin_s;

endpackage : pafm_pkg
`default_nettype wire

// ==== logic/pafm_port_regs.sv ====
`timescale 1ns/100ps
`default_nettype none
module pafm_port_regs (
    input  wire logic              clock,
    input  wire logic              rst,
    input  wire logic              addr_we,
    input  wire logic              ctl_we,
    input  wire logic              out_we,
    input  wire logic [7:0]        wdata,
    input  wire logic              has_fs,
    output var  pafm_pkg::pafm_port_s port_r,
    output logic [7:0]             ctl_rd
);
    import pafm_pkg::*;

    pafm_port_s st_r;
    pafm_port_s st_nxt;

    // ------------------------------------------------------------
    // Subregister access
    // ------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        if (addr_we) begin
            st_nxt.sel = wdata;
        end
        if (out_we) begin
            st_nxt.dout = wdata;
        end
        if (ctl_we) begin
            unique case (st_r.sel)
                SUB_DIR: st_nxt.dir = wdata;
                SUB_AF:  st_nxt.af  = wdata;
                SUB_FS1: if (has_fs) st_nxt.fs1 = wdata;
                SUB_FS2: if (has_fs) st_nxt.fs2 = wdata;
                default: st_nxt = st_nxt;
            endcase
        end
    end

    always_comb begin
        unique case (st_r.sel)
            SUB_DIR: ctl_rd = st_r.dir;
            SUB_AF:  ctl_rd = st_r.af;
            SUB_FS1: ctl_rd = st_r.fs1;
            SUB_FS2: ctl_rd = st_r.fs2;
            default: ctl_rd = RST_BYTE;
        endcase
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            st_r <= '{sel: RST_BYTE, dir: RST_DIR, af: RST_BYTE,
                      fs1: RST_BYTE, fs2: RST_BYTE, dout: RST_BYTE};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign port_r = st_r;

endmodule : pafm_port_regs
`default_nettype wire

// ==== logic/pafm_mux.sv ====
`timescale 1ns/100ps
`default_nettype none
//
// Contract
// - Port A has no function-set registers
// - Port A enable alone connects its function
// - Timer decides input or complemented output (here pa_periph_o drives the pin uncomplemented)
// - Port B first set bit alone selects
// - Port C first set bit alone selects
// - Port B analog inputs, pin 3 clock
// - Pin B5 reference only on 28-pin
// - Port C pins 0,1 analog/comparator/LED
// - Pin C2 analog six, LED, reference
// - Port C LED sink; pin 3 comparator
// - Four sink levels 3,7,13,20 mA
// - LED mode needs enable and set bit
// - LED enable register switches drivers
// - High and low registers encode level
// - 8-pin A2 is reset, bidirectional GPIO
// - A2 reverts to reset input in reset
// - Set register reached at subregister 07h
module pafm_mux (
    input  wire logic                  clock,
    input  wire logic                  rst,
    input  wire pafm_pkg::pafm_pkg_e   pkg_sel,
    input  wire logic [3:0]            addr,
    input  wire logic [7:0]            wdata,
    input  wire logic                  wr,
    input  wire logic                  rd,
    output logic [7:0]                 rdata,
    input  wire logic [7:0]            pa_in,
    input  wire logic [7:0]            pb_in,
    input  wire logic [7:0]            pc_in,
    output var  pafm_pkg::pafm_pin_s   pa_pin,
    output var  pafm_pkg::pafm_pin_s   pb_pin,
    output var  pafm_pkg::pafm_pin_s   pc_pin,
    input  wire logic [7:0]            pa_periph_o,
    input  wire logic [7:0]            pa_periph_oe,
    output logic [7:0]                 pa_periph_i,
    input  wire logic                  comparator_result_out,
    output logic                       external_clock_input,
    output logic [7:0]                 pb_analog_sel,
    output logic                       port_b_pin_five,
    output logic [2:0]                 pc_analog_sel,
    output logic                       port_c_pin_two,
    output logic [7:0]                 led_sink_on,
    output var  pafm_pkg::pafm_led_e   led_level [8],
    output logic                       reset_hold
);
    import pafm_pkg::*;

    typedef struct packed {
        logic [7:0] led_driver_enable_reg;
        logic [7:0] led_level_high_reg;
        logic [7:0] led_level_low_reg;
        logic [7:0] rdata;
        pafm_pin_s  pa;
        pafm_pin_s  pb;
        pafm_pin_s  pc;
        logic [7:0] pa_pi;
        logic       clk_in;
        logic [7:0] pb_an;
        logic       b5_ref;
        logic [2:0] pc_an;
        logic       c2_ref;
        logic [7:0] led_on;
        logic [15:0] lvl;
        logic       rhold;
        logic       a2_rst;
    } pafm_state_s;

    pafm_state_s st_r;
    pafm_state_s st_nxt;
    pafm_port_s  pa_r;
    pafm_port_s  pb_r;
    pafm_port_s  pc_r;
    logic [7:0]  pa_rd;
    logic [7:0]  pb_rd;
    logic [7:0]  pc_rd;
    logic [7:0]  pb_en;
    logic [7:0]  pc_en;
    logic [7:0]  pc_led;
    logic        is8;

    // ------------------------------------------------------------
    // Port configuration storage
    // ------------------------------------------------------------
    pafm_port_regs u_pa (
        .clock   (clock),
        .rst     (rst),
        .addr_we (wr && addr == ADR_PA_ADDR),
        .ctl_we  (wr && addr == ADR_PA_CTL),
        .out_we  (wr && addr == ADR_PA_OUT),
        .wdata   (wdata),
        .has_fs  (1'b0),
        .port_r  (pa_r),
        .ctl_rd  (pa_rd)
    );

    pafm_port_regs u_pb (
        .clock   (clock),
        .rst     (rst),
        .addr_we (wr && addr == ADR_PB_ADDR),
        .ctl_we  (wr && addr == ADR_PB_CTL),
        .out_we  (wr && addr == ADR_PB_OUT),
        .wdata   (wdata),
        .has_fs  (1'b1),
        .port_r  (pb_r),
        .ctl_rd  (pb_rd)
    );

    pafm_port_regs u_pc (
        .clock   (clock),
        .rst     (rst),
        .addr_we (wr && addr == ADR_PC_ADDR),
        .ctl_we  (wr && addr == ADR_PC_CTL),
        .out_we  (wr && addr == ADR_PC_OUT),
        .wdata   (wdata),
        .has_fs  (1'b1),
        .port_r  (pc_r),
        .ctl_rd  (pc_rd)
    );

    // ------------------------------------------------------------
    // Selection terms
    // ------------------------------------------------------------
    assign is8    = (pkg_sel == PKG_8PIN);
    assign pb_en  = pb_r.af & pb_r.fs1;
    assign pc_en  = pc_r.af & pc_r.fs1;
    assign pc_led = pc_en & PC_LED_MASK;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        if (wr) begin
            unique case (addr)
                ADR_LED_EN: st_nxt.led_driver_enable_reg = wdata;
                ADR_LED_HI: st_nxt.led_level_high_reg    = wdata;
                ADR_LED_LO: st_nxt.led_level_low_reg     = wdata;
                default:    st_nxt.rdata = st_nxt.rdata;
            endcase
        end
        st_nxt.rdata = RST_BYTE;
        if (rd) begin
            unique case (addr)
                ADR_PA_ADDR: st_nxt.rdata = pa_r.sel;
                ADR_PA_CTL:  st_nxt.rdata = pa_rd;
                ADR_PB_ADDR: st_nxt.rdata = pb_r.sel;
                ADR_PB_CTL:  st_nxt.rdata = pb_rd;
                ADR_PC_ADDR: st_nxt.rdata = pc_r.sel;
                ADR_PC_CTL:  st_nxt.rdata = pc_rd;
                ADR_LED_EN:  st_nxt.rdata = st_r.led_driver_enable_reg;
                ADR_LED_HI:  st_nxt.rdata = st_r.led_level_high_reg;
                ADR_LED_LO:  st_nxt.rdata = st_r.led_level_low_reg;
                ADR_PA_IN:   st_nxt.rdata = pa_in;
                ADR_PB_IN:   st_nxt.rdata = pb_in;
                ADR_PC_IN:   st_nxt.rdata = pc_in;
                ADR_PA_OUT:  st_nxt.rdata = pa_r.dout;
                ADR_PB_OUT:  st_nxt.rdata = pb_r.dout;
                ADR_PC_OUT:  st_nxt.rdata = pc_r.dout;
                default:     st_nxt.rdata = RST_BYTE;
            endcase
        end

        // Port A: enable alone hands the pin to its peripheral
        for (int i = 0; i < 8; i++) begin
            if (pa_r.af[i]) begin
                st_nxt.pa.o[i]  = pa_periph_o[i];
                st_nxt.pa.oe[i] = pa_periph_oe[i];
            end else begin
                st_nxt.pa.o[i]  = pa_r.dout[i];
                st_nxt.pa.oe[i] = ~pa_r.dir[i];
            end
        end
        st_nxt.pa_pi = pa_in & pa_r.af;
        // Shared reset pin: plain GPIO both ways, reset input otherwise
        // Reset-input mode stands from reset until port A functions are rewritten
        if (wr && addr == ADR_PA_CTL && pa_r.sel == SUB_AF) begin
            st_nxt.a2_rst = 1'b0;
        end
        st_nxt.rhold = 1'b0;
        if (is8 && (st_r.a2_rst || pa_r.af[PIN_RESET_A])) begin
            st_nxt.pa.oe[PIN_RESET_A] = 1'b0;
            st_nxt.rhold = ~pa_in[PIN_RESET_A];
        end

        // Port B: analog pins release the pad, pin 3 clock in
        for (int i = 0; i < 8; i++) begin
            st_nxt.pb.o[i]  = pb_r.dout[i];
            st_nxt.pb.oe[i] = ~pb_r.dir[i] & ~pb_r.af[i];
        end
        st_nxt.pb_an  = pb_en & PB_ANALOG_MASK;
        st_nxt.b5_ref = pb_en[PIN_VREF_B] && (pkg_sel == PKG_28PIN);
        st_nxt.clk_in = pb_r.af[PIN_CLK] && !pb_r.fs1[PIN_CLK]
                        && pb_in[PIN_CLK];

        // Port C: analog, comparator and LED sink
        for (int i = 0; i < 8; i++) begin
            st_nxt.pc.o[i]  = pc_r.dout[i];
            st_nxt.pc.oe[i] = ~pc_r.dir[i] & ~pc_r.af[i];
            if (pc_led[i] && st_r.led_driver_enable_reg[i]) begin
                st_nxt.pc.o[i]  = 1'b0;
                st_nxt.pc.oe[i] = 1'b1;
            end
        end
        if (pc_r.af[PIN_COMPARATOR_RESULT_OUT] && !pc_r.fs1[PIN_COMPARATOR_RESULT_OUT]) begin
            st_nxt.pc.o[PIN_COMPARATOR_RESULT_OUT]  = comparator_result_out;
            st_nxt.pc.oe[PIN_COMPARATOR_RESULT_OUT] = 1'b1;
        end
        st_nxt.pc_an  = pc_en[2:0];
        st_nxt.c2_ref = pc_en[PIN_VREF_C] && (pkg_sel == PKG_20PIN);
        st_nxt.led_on = pc_led & st_r.led_driver_enable_reg;
        for (int i = 0; i < 8; i++) begin
            st_nxt.lvl[2*i +: 2] = {st_r.led_level_high_reg[i],
                                    st_r.led_level_low_reg[i]};
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            st_r        <= '0;
            st_r.a2_rst <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign rdata                = st_r.rdata;
    assign pa_pin               = st_r.pa;
    assign pb_pin               = st_r.pb;
    assign pc_pin               = st_r.pc;
    assign pa_periph_i          = st_r.pa_pi;
    assign external_clock_input = st_r.clk_in;
    assign pb_analog_sel        = st_r.pb_an;
    assign port_b_pin_five      = st_r.b5_ref;
    assign pc_analog_sel        = st_r.pc_an;
    assign port_c_pin_two       = st_r.c2_ref;
    assign led_sink_on          = st_r.led_on;
    assign reset_hold           = st_r.rhold;

    for (genvar g = 0; g < 8; g++) begin : g_lvl
        assign led_level[g] = pafm_led_e'(st_r.lvl[2*g +: 2]);
    end

endmodule : pafm_mux
`default_nettype wire

// ==== test/pafm_pads.sv ====
`timescale 1ns/100ps
`default_nettype none
module pafm_pads (
    input  wire logic                rst,
    input  wire pafm_pkg::pafm_pin_s pa_pin,
    input  wire pafm_pkg::pafm_pin_s pb_pin,
    input  wire pafm_pkg::pafm_pin_s pc_pin,
    input  wire logic [7:0]          xa,
    input  wire logic [7:0]          xb,
    input  wire logic [7:0]          xc,
    output logic [7:0]               pa_in,
    output logic [7:0]               pb_in,
    output logic [7:0]               pc_in
);
    import pafm_pkg::*;
    // ------------------------------------------------------------
    // Pad levels: device drive wins, else outside level, except A2 reads high during reset
    // ------------------------------------------------------------
    always_comb begin
        pa_in = (pa_pin.oe & pa_pin.o) | (~pa_pin.oe & xa);
        if (rst) begin
            pa_in[2] = 1'b1;
        end
        pb_in = (pb_pin.oe & pb_pin.o) | (~pb_pin.oe & xb);
        pc_in = (pc_pin.oe & pc_pin.o) | (~pc_pin.oe & xc);
    end
endmodule : pafm_pads
`default_nettype wire

// ==== test/pafm_mux_properties.sv ====
`timescale 1ns/100ps
`default_nettype none
module pafm_mux_properties (
    input  wire logic                clock,
    input  wire logic                rst,
    input  wire pafm_pkg::pafm_pkg_e pkg_sel,
    input  wire logic                rd,
    input  wire logic [7:0]          rdata,
    input  wire logic [7:0]          pa_in,
    input  wire logic [7:0]          pb_in,
    input  wire logic [7:0]          pa_periph_i,
    input  wire logic                external_clock_input,
    input  wire logic [7:0]          pb_analog_sel,
    input  wire logic                port_b_pin_five,
    input  wire logic                port_c_pin_two,
    input  wire logic [7:0]          led_sink_on,
    input  wire pafm_pkg::pafm_pin_s pc_pin,
    input  wire logic                reset_hold
);
    import pafm_pkg::*;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    rd_idle_a: assert property (!$past(rd) |-> rdata == 8'h00)
        else $error("read data outside read slot");
    pb_reserved_a: assert property (pb_analog_sel[7:5] == 3'h0)
        else $error("reserved port b pin selected");
    vref_b_pkg_a: assert property (port_b_pin_five |-> $past(pkg_sel) == PKG_28PIN)
        else $error("b reference on wrong package");
    vref_c_pkg_a: assert property (port_c_pin_two |-> $past(pkg_sel) == PKG_20PIN)
        else $error("c reference on wrong package");
    reset_hold_a: assert property (reset_hold |-> $past(pkg_sel) == PKG_8PIN && !$past(pa_in[2]))
        else $error("reset hold without low pin");
    led_sink_a: assert property ((led_sink_on & ~(pc_pin.oe & ~pc_pin.o)) == 8'h00)
        else $error("led driver on but pin not sinking");
    clk_in_a: assert property (external_clock_input |-> $past(pb_in[3]))
        else $error("clock input not from pin");
    periph_in_a: assert property ((pa_periph_i & ~$past(pa_in)) == 8'h00)
        else $error("peripheral input not from pin");
endmodule : pafm_mux_properties

bind pafm_mux pafm_mux_properties chk_u (.clock, .rst, .pkg_sel, .rd, .rdata, .pa_in, .pb_in,
    .pa_periph_i, .external_clock_input, .pb_analog_sel, .port_b_pin_five, .port_c_pin_two,
    .led_sink_on, .pc_pin, .reset_hold);
`default_nettype wire

// ==== test/pafm_mux_tb.sv ====
`timescale 1ns/100ps
`default_nettype none
module pafm_mux_tb;
    import pafm_pkg::*;
    logic       clock, rst, wr, rd, cmp, ext_clk, vb, vc, hold;
    logic [3:0] addr;
    logic [7:0] wdata, rdata, pa_in, pb_in, pc_in, pa_po, pa_poe, pa_pi, pb_an, led_on;
    logic [7:0] xa, xb, xc, af, fs, dir, en, hi, lo;
    logic [2:0] pc_an;
    pafm_pin_s  pa_pin, pb_pin, pc_pin;
    pafm_pkg_e  pkg;
    pafm_led_e  lvl [8];
    int         bad_count, tests_run, cyc;

    pafm_mux dut_u (.clock(clock), .rst(rst), .pkg_sel(pkg), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .pa_in(pa_in), .pb_in(pb_in), .pc_in(pc_in),
        .pa_pin(pa_pin), .pb_pin(pb_pin), .pc_pin(pc_pin), .pa_periph_o(pa_po),
        .pa_periph_oe(pa_poe), .pa_periph_i(pa_pi), .comparator_result_out(cmp),
        .external_clock_input(ext_clk), .pb_analog_sel(pb_an), .port_b_pin_five(vb),
        .pc_analog_sel(pc_an), .port_c_pin_two(vc), .led_sink_on(led_on), .led_level(lvl),
        .reset_hold(hold));
    pafm_pads pads_u (.rst(rst), .pa_pin(pa_pin), .pb_pin(pb_pin), .pc_pin(pc_pin),
        .xa(xa), .xb(xb), .xc(xc), .pa_in(pa_in), .pb_in(pb_in), .pc_in(pc_in));

    always #5 clock = ~clock;
    // ------------------------------------------------------------
    // Bus tasks and checks
    // ------------------------------------------------------------
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : print_verdict
    always @(posedge clock) begin
        cyc++;
        if (cyc == 5000) begin
            bad_count++;
            print_verdict();
        end
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        rd <= 1'b0;
        @(posedge clock);
    endtask : wr_reg
    task automatic idle(input int n);
        wr <= 1'b0;
        rd <= 1'b0;
        repeat (n) @(posedge clock);
    endtask : idle
    task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
        addr <= a;
        rd <= 1'b1;
        wr <= 1'b0;
        @(posedge clock);
        rd <= 1'b0;
        #1 chk(rdata, exp);
    endtask : rd_chk
    task automatic sub(input logic [3:0] a, input logic [7:0] s, input logic [7:0] d);
        wr_reg(a, s);
        wr_reg(a + 4'h1, d);
    endtask : sub
    function automatic logic [7:0] gpio_oe(input logic [7:0] d, input logic [7:0] a);
        return ~d & ~a;
    endfunction : gpio_oe
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        {clock, wr, rd, cmp, addr, wdata, pa_po, pa_poe, xa, xb, xc, cyc} = '0;
        {bad_count, tests_run} = '0;
        rst = 1'b1;
        pkg = PKG_20PIN;
        void'($urandom(32'h0000_106c));
        repeat (6) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        wr_reg(ADR_PA_ADDR, SUB_DIR);
        rd_chk(ADR_PA_CTL, RST_DIR);
        rd_chk(ADR_LED_HI, RST_BYTE);
        chk(pb_pin.oe, 8'h00);
        sub(ADR_PA_ADDR, SUB_FS1, 8'($urandom));
        rd_chk(ADR_PA_CTL, 8'h00);
        for (int i = 0; i < 8; i++) begin
            af = i ? 8'($urandom) : 8'hFF;
            pa_po <= 8'($urandom);
            pa_poe <= 8'($urandom);
            xa <= 8'($urandom);
            sub(ADR_PA_ADDR, SUB_AF, af);
            idle(3);
            chk(pa_pin.oe, af & pa_poe);
            chk(pa_pin.o & pa_pin.oe, pa_po & af & pa_poe);
            chk(pa_pi, af & ((pa_poe & pa_po) | (~pa_poe & xa)));
        end
        $display("port a test done");
        for (int i = 0; i < 16; i++) begin
            pkg <= i[0] ? PKG_28PIN : PKG_20PIN;
            af = i ? 8'($urandom) : 8'hFF;
            fs = i ? 8'($urandom) : 8'hF7;
            dir = 8'($urandom);
            xb <= 8'($urandom);
            sub(ADR_PB_ADDR, SUB_DIR, dir);
            sub(ADR_PB_ADDR, SUB_AF, af);
            sub(ADR_PB_ADDR, SUB_FS1, fs);
            sub(ADR_PB_ADDR, SUB_FS2, ~fs);
            wr_reg(ADR_PB_OUT, ~dir);
            rd_chk(ADR_PB_CTL, ~fs);
            rd_chk(ADR_PB_OUT, ~dir);
            idle(3);
            chk(pb_pin.o, ~dir);
            chk(pb_an, af & fs & 8'h1F);
            chk(vb, af[5] & fs[5] & i[0]);
            chk(ext_clk, af[3] & ~fs[3] & xb[3]);
            chk(pb_pin.oe, gpio_oe(dir, af));
        end
        $display("port b test done");
        for (int i = 0; i < 16; i++) begin
            pkg <= i[0] ? PKG_20PIN : PKG_28PIN;
            af = i ? 8'($urandom) : 8'hFF;
            fs = i ? 8'($urandom) : 8'hF7;
            {en, hi, lo} = 24'($urandom);
            cmp <= 1'($urandom);
            xc <= 8'($urandom);
            sub(ADR_PC_ADDR, SUB_AF, af);
            sub(ADR_PC_ADDR, SUB_FS1, fs);
            sub(ADR_PC_ADDR, SUB_FS2, ~fs);
            wr_reg(ADR_LED_EN, en);
            wr_reg(ADR_LED_HI, hi);
            wr_reg(ADR_LED_LO, lo);
            rd_chk(ADR_LED_HI, hi);
            idle(3);
            chk(led_on, af & fs & en);
            chk(pc_an, af[2:0] & fs[2:0]);
            chk(vc, af[2] & fs[2] & i[0]);
            if (af[3] & ~fs[3]) begin
                chk({pc_pin.oe[3], pc_pin.o[3]}, {1'b1, cmp});
            end
            for (int k = 0; k < 8; k++) begin
                chk(lvl[k], {hi[k], lo[k]});
            end
        end
        $display("port c test done");
        pkg <= PKG_8PIN;
        xa <= 8'h00;
        pa_poe <= 8'h00;
        sub(ADR_PA_ADDR, SUB_AF, 8'h00);
        sub(ADR_PA_ADDR, SUB_DIR, 8'hFB);
        idle(3);
        chk(pa_pin.oe, 8'h04);
        sub(ADR_PA_ADDR, SUB_AF, 8'h04);
        idle(3);
        chk(hold, 1'b1);
        xa <= 8'h04;
        idle(3);
        chk(hold, 1'b0);
        xa <= 8'h00;
        rst <= 1'b1;
        idle(3);
        rst <= 1'b0;
        idle(3);
        chk(pa_pin.oe, 8'h00);
        chk(hold, 1'b1);
        xa <= 8'h04;
        idle(3);
        chk(hold, 1'b0);
        $display("shared reset test done");
        print_verdict();
    end
endmodule : pafm_mux_tb
`default_nettype wire
